/* logic/ptd_pkg.sv */
`default_nettype none
package ptd_pkg;
    // sample width of the channel data
    localparam int PTD_SW = 16;
    localparam int PTD_AW = 12;
    localparam int PTD_DW = 32;

    // register byte offsets
    localparam logic [PTD_AW-1:0] PTD_CTRL_OFS = 12'h000;
    localparam logic [PTD_AW-1:0] PTD_LEVEL_OFS = 12'h004;
    localparam logic [PTD_AW-1:0] PTD_GLITCH_OFS = 12'h008;
    localparam logic [PTD_AW-1:0] PTD_LOWER_OFS = 12'h00c;
    localparam logic [PTD_AW-1:0] PTD_UPPER_OFS = 12'h010;
    localparam logic [PTD_AW-1:0] PTD_RHIGH_OFS = 12'h014;
    localparam logic [PTD_AW-1:0] PTD_RLOW_OFS = 12'h018;
    localparam logic [PTD_AW-1:0] PTD_HOLDOFF_OFS = 12'h01c;
    localparam logic [PTD_AW-1:0] PTD_TIMEOUT_OFS = 12'h020;
    localparam logic [PTD_AW-1:0] PTD_CMD_OFS = 12'h024;
    localparam logic [PTD_AW-1:0] PTD_STATUS_OFS = 12'h028;
    localparam logic [PTD_AW-1:0] PTD_LASTW_OFS = 12'h02c;
    localparam logic [PTD_AW-1:0] PTD_MIDLVL_OFS = 12'h030;

    // command register bits
    localparam int PTD_CMD_FORCE_BIT = 0;
    localparam int PTD_CMD_MID_BIT = 1;

    // holdoff is entered in percent
    localparam logic [7:0] PTD_HOLDOFF_MAX = 8'h64;

    typedef enum logic [1:0] {
        PTD_CLASS_GLITCH = 2'h0,
        PTD_CLASS_RUNT = 2'h1,
        PTD_CLASS_WIDTH = 2'h2
    } ptd_class_t;

    typedef enum logic [1:0] {
        PTD_POL_POS = 2'h0,
        PTD_POL_NEG = 2'h1,
        PTD_POL_EITHER = 2'h2
    } ptd_pol_t;

    typedef enum logic [1:0] {
        PTD_LSEL_USER = 2'h0,
        PTD_LSEL_TTL = 2'h1,
        PTD_LSEL_ECL = 2'h2,
        PTD_LSEL_MID = 2'h3
    } ptd_lsel_t;

    typedef enum logic [2:0] {
        PTD_RS_IDLE = 3'b001,
        PTD_RS_POS = 3'b010,
        PTD_RS_NEG = 3'b100
    } ptd_runt_t;

    typedef enum logic [1:0] {
        PTD_MS_IDLE = 2'b01,
        PTD_MS_SCAN = 2'b10
    } ptd_mid_t;

    // control word, bit 0 upward: class, polarity, reject, outside, normal, level select, source
    typedef struct packed {
        logic [1:0] source;
        ptd_lsel_t level_sel;
        logic mode_normal;
        logic range_outside_select;
        logic glitch_reject;
        ptd_pol_t polarity;
        ptd_class_t pclass;
    } ptd_ctrl_t;

    localparam int PTD_CTRL_W = $bits(ptd_ctrl_t);
    localparam ptd_ctrl_t PTD_CTRL_RST = '{2'h0, PTD_LSEL_USER, 1'b0, 1'b0, 1'b0, PTD_POL_POS, PTD_CLASS_GLITCH};
endpackage : ptd_pkg
`default_nettype wire

/* logic/ptd_pulse_trigger_detector.sv */
// Contract
// - trigger source is one selectable channel, or auxiliary input on small variant
// - auto mode starts an acquisition when the time-base timeout expires
// - normal mode acquires only on trigger; a force gives exactly one
// - holdoff set in percent suppresses new triggers during the interval
// - glitch class checks positive, negative or both pulses against one width
// - glitch accept triggers on selected pulses narrower than glitch width
// - glitch reject triggers on selected pulses wider than glitch width
// - level may be preset to the TTL threshold or freely entered
// - midpoint request finds both peaks and sets level halfway between
// - positive runt: rise through low, fall back, never reach high
// - negative runt: fall through high, rise back, never reach low
// - either runt: cross a threshold, recross it, never touch the other
// - runt trigger fires when the first threshold is recrossed
// - two independent runt levels, high and low
// - width class has only positive or negative polarity
// - within limits triggers when width lies inside lower..upper
// - outside limits triggers when width lies outside lower..upper
// - upper is maximum valid width, lower is minimum, in time units
// - lower limit is always kept at or below the upper limit
//
// The register offsets and the APB register port are this design's own decisions.
`default_nettype none
module ptd_pulse_trigger_detector #(
    parameter int CNT_W = 16,
    parameter int HOLDOFF_STEP_CYCLES = 16,
    parameter int MID_SCAN_CYCLES = 1024,
    parameter bit FOUR_CHANNELS = 1'b1,
    parameter logic signed [15:0] TTL_CODE = 16'h0100,
    parameter logic signed [15:0] ECL_CODE = 16'hff00
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic signed [ptd_pkg::PTD_SW-1:0] i_input_channel_one,
    input wire logic signed [ptd_pkg::PTD_SW-1:0] i_input_channel_two,
    input wire logic signed [ptd_pkg::PTD_SW-1:0] i_input_channel_three,
    input wire logic signed [ptd_pkg::PTD_SW-1:0] i_input_channel_four,
    input wire logic signed [ptd_pkg::PTD_SW-1:0] i_auxiliary_input_one,
    input wire logic signed [ptd_pkg::PTD_SW-1:0] i_auxiliary_input_two,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [ptd_pkg::PTD_AW-1:0] i_paddr,
    input wire logic [ptd_pkg::PTD_DW-1:0] i_pwdata,
    output logic [ptd_pkg::PTD_DW-1:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_trigger,
    output logic o_acquire
);
    import ptd_pkg::*;

    localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
    localparam logic [31:0] MID_LAST = 32'(MID_SCAN_CYCLES - 1);
    localparam logic [31:0] HOLD_STEP = 32'(HOLDOFF_STEP_CYCLES);

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (v == CNT_MAX) ? v : v + 1'b1;
    endfunction : sat_inc

    function automatic logic addr_ok(input logic [PTD_AW-1:0] a);
        return a inside {PTD_CTRL_OFS, PTD_LEVEL_OFS, PTD_GLITCH_OFS, PTD_LOWER_OFS, PTD_UPPER_OFS,
                         PTD_RHIGH_OFS, PTD_RLOW_OFS, PTD_HOLDOFF_OFS, PTD_TIMEOUT_OFS, PTD_CMD_OFS,
                         PTD_STATUS_OFS, PTD_LASTW_OFS, PTD_MIDLVL_OFS};
    endfunction : addr_ok

    ptd_ctrl_t cfg_r;
    logic signed [PTD_SW-1:0] level_r, rhigh_r, rlow_r, mid_level_r;
    logic [CNT_W-1:0] glitch_r, lower_r, upper_r, cnt_r, last_w_r;
    logic [7:0] holdoff_pct_r;
    logic [31:0] timeout_r, tmo_cnt_r, hold_cnt_r, mid_cnt_r, hold_load;
    logic wr_en, rd_setup, cfg_change, force_req, mid_req;
    logic force_pend_r, trig_r, acq_r;
    logic signed [PTD_SW-1:0] src, samp_r, act_level, pmax_r, pmin_r;
    logic above, above_r, seen_r, in_lo, in_hi, in_mid, lo_r, hi_r;
    logic pos_end, neg_end, end_sel, glitch_hit, width_hit, runt_hit, class_hit, trig, tmo_hit, acq;
    ptd_runt_t runt_st_r;
    ptd_mid_t mid_st_r;
    logic [PTD_DW-1:0] rd_val;

    // apb: zero wait, read data latched in the setup cycle
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign rd_setup = i_psel && !i_penable && !i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !addr_ok(i_paddr);
    assign cfg_change = wr_en && (i_paddr inside {PTD_CTRL_OFS, PTD_GLITCH_OFS, PTD_LOWER_OFS,
                                                  PTD_UPPER_OFS, PTD_RHIGH_OFS, PTD_RLOW_OFS});
    assign force_req = wr_en && (i_paddr == PTD_CMD_OFS) && i_pwdata[PTD_CMD_FORCE_BIT];
    assign mid_req = wr_en && (i_paddr == PTD_CMD_OFS) && i_pwdata[PTD_CMD_MID_BIT];

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_r <= PTD_CTRL_RST;
            level_r <= '0;
            glitch_r <= '0;
            lower_r <= '0;
            upper_r <= '0;
            rhigh_r <= '0;
            rlow_r <= '0;
            holdoff_pct_r <= '0;
            timeout_r <= '0;
        end else if (wr_en) begin
            case (i_paddr)
                PTD_CTRL_OFS: cfg_r <= ptd_ctrl_t'(i_pwdata[PTD_CTRL_W-1:0]);
                PTD_LEVEL_OFS: level_r <= i_pwdata[PTD_SW-1:0];
                PTD_GLITCH_OFS: glitch_r <= i_pwdata[CNT_W-1:0];
                PTD_LOWER_OFS: lower_r <= (i_pwdata[CNT_W-1:0] > upper_r) ? upper_r : i_pwdata[CNT_W-1:0];
                PTD_UPPER_OFS: begin
                    upper_r <= i_pwdata[CNT_W-1:0];
                    lower_r <= (i_pwdata[CNT_W-1:0] < lower_r) ? i_pwdata[CNT_W-1:0] : lower_r;
                end
                PTD_RHIGH_OFS: rhigh_r <= i_pwdata[PTD_SW-1:0];
                PTD_RLOW_OFS: rlow_r <= i_pwdata[PTD_SW-1:0];
                PTD_HOLDOFF_OFS: begin
                    holdoff_pct_r <= (i_pwdata[7:0] > PTD_HOLDOFF_MAX) ? PTD_HOLDOFF_MAX : i_pwdata[7:0];
                end
                PTD_TIMEOUT_OFS: timeout_r <= i_pwdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_val = '0;
        case (i_paddr)
            PTD_CTRL_OFS: rd_val[PTD_CTRL_W-1:0] = cfg_r;
            PTD_LEVEL_OFS: rd_val[PTD_SW-1:0] = level_r;
            PTD_GLITCH_OFS: rd_val[CNT_W-1:0] = glitch_r;
            PTD_LOWER_OFS: rd_val[CNT_W-1:0] = lower_r;
            PTD_UPPER_OFS: rd_val[CNT_W-1:0] = upper_r;
            PTD_RHIGH_OFS: rd_val[PTD_SW-1:0] = rhigh_r;
            PTD_RLOW_OFS: rd_val[PTD_SW-1:0] = rlow_r;
            PTD_HOLDOFF_OFS: rd_val[7:0] = holdoff_pct_r;
            PTD_TIMEOUT_OFS: rd_val = timeout_r;
            PTD_STATUS_OFS: rd_val[7:0] = {runt_st_r, mid_st_r == PTD_MS_SCAN, force_pend_r,
                                           hold_cnt_r != '0, seen_r, above};
            PTD_LASTW_OFS: rd_val[CNT_W-1:0] = last_w_r;
            PTD_MIDLVL_OFS: rd_val[PTD_SW-1:0] = act_level;
            default: rd_val = '0;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_prdata <= '0;
        end else if (rd_setup) begin
            o_prdata <= rd_val;
        end
    end

    // source select; the small variant has auxiliary inputs in place of three and four
    always_comb begin
        case (cfg_r.source)
            2'h0: src = i_input_channel_one;
            2'h1: src = i_input_channel_two;
            2'h2: src = FOUR_CHANNELS ? i_input_channel_three : i_auxiliary_input_one;
            default: src = FOUR_CHANNELS ? i_input_channel_four : i_auxiliary_input_two;
        endcase
    end

    always_comb begin
        case (cfg_r.level_sel)
            PTD_LSEL_TTL: act_level = TTL_CODE;
            PTD_LSEL_ECL: act_level = ECL_CODE;
            PTD_LSEL_MID: act_level = mid_level_r;
            default: act_level = level_r;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            samp_r <= '0;
            lo_r <= 1'b0;
            hi_r <= 1'b0;
        end else begin
            samp_r <= src;
            lo_r <= in_lo;
            hi_r <= in_hi;
        end
    end

    // midpoint search over a fixed window of samples
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            mid_st_r <= PTD_MS_IDLE;
            mid_cnt_r <= '0;
            pmax_r <= '0;
            pmin_r <= '0;
            mid_level_r <= '0;
        end else begin
            case (mid_st_r)
                PTD_MS_IDLE: begin
                    if (mid_req) begin
                        mid_st_r <= PTD_MS_SCAN;
                        mid_cnt_r <= '0;
                        pmax_r <= samp_r;
                        pmin_r <= samp_r;
                    end
                end
                PTD_MS_SCAN: begin
                    if (samp_r > pmax_r) begin
                        pmax_r <= samp_r;
                    end
                    if (samp_r < pmin_r) begin
                        pmin_r <= samp_r;
                    end
                    mid_cnt_r <= mid_cnt_r + 32'h1;
                    if (mid_cnt_r == MID_LAST) begin
                        mid_st_r <= PTD_MS_IDLE;
                        mid_level_r <= PTD_SW'(({pmax_r[PTD_SW-1], pmax_r} + {pmin_r[PTD_SW-1], pmin_r}) >>> 1);
                    end
                end
                default: mid_st_r <= PTD_MS_IDLE;
            endcase
        end
    end

    // pulse width measurement at the trigger level
    assign above = samp_r >= act_level;
    assign pos_end = seen_r && above_r && !above;
    assign neg_end = seen_r && !above_r && above;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            above_r <= 1'b0;
            seen_r <= 1'b0;
            cnt_r <= '0;
        end else begin
            above_r <= above;
            if (cfg_change) begin
                seen_r <= 1'b0;
                cnt_r <= '0;
            end else if (above != above_r) begin
                seen_r <= 1'b1;
                cnt_r <= {{(CNT_W-1){1'b0}}, 1'b1};
            end else begin
                cnt_r <= sat_inc(cnt_r);
            end
        end
    end

    always_comb begin
        case (cfg_r.polarity)
            PTD_POL_NEG: end_sel = neg_end;
            PTD_POL_EITHER: end_sel = (cfg_r.pclass == PTD_CLASS_WIDTH) ? pos_end : (pos_end || neg_end);
            default: end_sel = pos_end;
        endcase
    end

    assign glitch_hit = end_sel && (cfg_r.glitch_reject ? (cnt_r > glitch_r) : (cnt_r < glitch_r));
    assign width_hit = end_sel && (cfg_r.range_outside_select ?
                       (cnt_r < lower_r || cnt_r > upper_r) : (cnt_r >= lower_r && cnt_r <= upper_r));

    // runt detection on the two thresholds
    assign in_lo = samp_r < rlow_r;
    assign in_hi = samp_r >= rhigh_r;
    assign in_mid = !in_lo && !in_hi;
    assign runt_hit = (runt_st_r == PTD_RS_POS && in_lo) || (runt_st_r == PTD_RS_NEG && in_hi);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            runt_st_r <= PTD_RS_IDLE;
        end else if (cfg_change || cfg_r.pclass != PTD_CLASS_RUNT) begin
            runt_st_r <= PTD_RS_IDLE;
        end else begin
            case (runt_st_r)
                PTD_RS_IDLE: begin
                    if (lo_r && in_mid && cfg_r.polarity != PTD_POL_NEG) begin
                        runt_st_r <= PTD_RS_POS;
                    end else if (hi_r && in_mid && cfg_r.polarity != PTD_POL_POS) begin
                        runt_st_r <= PTD_RS_NEG;
                    end
                end
                PTD_RS_POS, PTD_RS_NEG: begin
                    if (in_hi || in_lo) begin
                        runt_st_r <= PTD_RS_IDLE;
                    end
                end
                default: runt_st_r <= PTD_RS_IDLE;
            endcase
        end
    end

    always_comb begin
        case (cfg_r.pclass)
            PTD_CLASS_GLITCH: class_hit = glitch_hit;
            PTD_CLASS_RUNT: class_hit = runt_hit;
            PTD_CLASS_WIDTH: class_hit = width_hit;
            default: class_hit = 1'b0;
        endcase
    end

    // trigger qualification, holdoff, auto timeout and force
    assign hold_load = 32'(holdoff_pct_r) * HOLD_STEP;
    assign trig = class_hit && !cfg_change && hold_cnt_r == '0;
    assign tmo_hit = !cfg_r.mode_normal && timeout_r != '0 && tmo_cnt_r >= timeout_r;
    assign acq = trig || force_pend_r || tmo_hit;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold_cnt_r <= '0;
        end else if (acq) begin
            hold_cnt_r <= hold_load;
        end else if (hold_cnt_r != '0) begin
            hold_cnt_r <= hold_cnt_r - 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tmo_cnt_r <= '0;
        end else if (acq || cfg_r.mode_normal) begin
            tmo_cnt_r <= '0;
        end else if (tmo_cnt_r != 32'hffffffff) begin
            tmo_cnt_r <= tmo_cnt_r + 32'h1;
        end
    end

    // a new force arriving as the old one is served stays pending
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            force_pend_r <= 1'b0;
        end else if (force_req) begin
            force_pend_r <= 1'b1;
        end else if (acq) begin
            force_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trig_r <= 1'b0;
            acq_r <= 1'b0;
            last_w_r <= '0;
        end else begin
            trig_r <= trig;
            acq_r <= acq;
            if (trig) begin
                last_w_r <= cnt_r;
            end
        end
    end

    assign o_trigger = trig_r;
    assign o_acquire = acq_r;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_force_req;
        force_req;
    endsequence
    sequence s_force_served;
        force_pend_r ##1 o_acquire;
    endsequence
    sequence s_pos_armed;
        runt_st_r == PTD_RS_POS && in_lo;
    endsequence
    property p_force_once;
        s_force_req |=> s_force_served;
    endproperty
    a_force_once: assert property (p_force_once) else $error("force did not acquire");
    property p_normal_only_trig;
        cfg_r.mode_normal && !force_pend_r && !trig |=> !o_acquire;
    endproperty
    a_normal_only_trig: assert property (p_normal_only_trig) else $error("untriggered normal acquisition");
    property p_auto_timeout;
        tmo_hit |=> o_acquire ##1 (tmo_cnt_r <= 32'h1);
    endproperty
    a_auto_timeout: assert property (p_auto_timeout) else $error("auto timeout lost");
    property p_holdoff;
        acq && hold_load > 32'h1 |=> hold_cnt_r == $past(hold_load) ##1 !o_trigger;
    endproperty
    a_holdoff: assert property (p_holdoff) else $error("trigger during holdoff");
    property p_glitch_width;
        o_trigger && $past(cfg_r.pclass) == PTD_CLASS_GLITCH |->
            ($past(cfg_r.glitch_reject) ? $past(cnt_r) > $past(glitch_r) : $past(cnt_r) < $past(glitch_r));
    endproperty
    a_glitch_width: assert property (p_glitch_width) else $error("glitch width mismatch");
    property p_width_range;
        o_trigger && $past(cfg_r.pclass) == PTD_CLASS_WIDTH && !$past(cfg_r.range_outside_select) |->
            last_w_r >= lower_r && last_w_r <= upper_r;
    endproperty
    a_width_range: assert property (p_width_range) else $error("width outside limits");
    property p_limits_order;
        lower_r <= upper_r;
    endproperty
    a_limits_order: assert property (p_limits_order) else $error("lower limit above upper");
    property p_runt_fire;
        s_pos_armed and (cfg_r.pclass == PTD_CLASS_RUNT && hold_cnt_r == '0 && !cfg_change) |=> o_trigger;
    endproperty
    a_runt_fire: assert property (p_runt_fire) else $error("runt recross missed");
    property p_cnt_sat;
        cnt_r == CNT_MAX && above == above_r && !cfg_change |=> cnt_r == CNT_MAX;
    endproperty
    a_cnt_sat: assert property (p_cnt_sat) else $error("width counter wrapped");
    property p_clear_on_change;
        cfg_change |=> runt_st_r == PTD_RS_IDLE && !seen_r ##1 !o_trigger;
    endproperty
    a_clear_on_change: assert property (p_clear_on_change) else $error("state kept after change");
    // sum kept one bit wider so two large peaks do not overflow
    property p_mid_level;
        mid_st_r == PTD_MS_SCAN && mid_cnt_r == MID_LAST |=>
            mid_level_r == PTD_SW'(((PTD_SW+1)'($past(pmax_r)) + (PTD_SW+1)'($past(pmin_r))) >>> 1);
    endproperty
    a_mid_level: assert property (p_mid_level) else $error("midpoint level wrong");
endmodule : ptd_pulse_trigger_detector
`default_nettype wire

/* testbench/ptd_pulse_trigger_detector_test.sv */
`default_nettype none
module ptd_pulse_trigger_detector_test;
    timeunit 1ns;
    timeprecision 1ps;
    import ptd_pkg::*;
    localparam logic [15:0] HI = 16'h0064;
    localparam logic [15:0] LO = 16'hff9c;
    logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic [15:0] ch1 = 16'hff9c;
    logic [15:0] ch2 = 16'h0000;
    logic rdy, err, e, trg, acq;
    int mismatches = 0, compares = 0, n;
    always #4 clk = ~clk;
    ptd_pulse_trigger_detector #(.HOLDOFF_STEP_CYCLES(1), .MID_SCAN_CYCLES(8)) dut_u (
        .i_clk(clk), .i_reset_n(rst_n), .i_input_channel_one(ch1), .i_input_channel_two(ch2),
        .i_input_channel_three(16'h0000), .i_input_channel_four(ch2), .i_auxiliary_input_one(16'h0000),
        .i_auxiliary_input_two(16'h0000), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .o_trigger(trg), .o_acquire(acq));
    task conclude;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (rdy !== 1'b1 && k < 20);
        if (k >= 20) begin
            mismatches++;
            conclude();
        end
        rd = prd;
        e = err;
        psel <= 1'b0;
        pen <= 1'b0;
        // one idle edge, so the next setup never reassigns psel in the same step
        @(posedge clk);
    endtask : apb
    // lead of base level, pulse of w cycles, tail of base level; triggers counted
    task pls(input logic [15:0] p, input logic [15:0] b, input int w);
        n = 0;
        for (int i = 0; i < 16 + w; i++) begin
            ch1 <= (i >= 8 && i < 8 + w) ? p : b;
            @(posedge clk);
            if (trg === 1'b1) n++;
        end
    endtask : pls
    task t_regs;
        apb(1'b0, PTD_CTRL_OFS, 32'h0);
        chk(rd, 32'h0, "ctrl reset");
        apb(1'b0, 12'h100, 32'h0);
        chk(e, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped read");
        apb(1'b1, PTD_CMD_OFS, 32'h2);
        ch1 <= 16'h012c;
        repeat (12) @(posedge clk);
        ch1 <= LO;
        apb(1'b1, PTD_CTRL_OFS, 32'h180);
        apb(1'b0, PTD_MIDLVL_OFS, 32'h0);
        chk(rd, 32'h64, "midpoint level");
        apb(1'b1, PTD_CTRL_OFS, 32'h80);
        apb(1'b0, PTD_MIDLVL_OFS, 32'h0);
        chk(rd, 32'h100, "ttl level");
        ch2 <= HI;
        apb(1'b1, PTD_CTRL_OFS, 32'h200);
        apb(1'b0, PTD_STATUS_OFS, 32'h0);
        chk(rd[0], 1'b1, "source two");
        apb(1'b1, PTD_CTRL_OFS, 32'h600);
        apb(1'b0, PTD_STATUS_OFS, 32'h0);
        chk(rd[0], 1'b1, "source four");
        apb(1'b1, PTD_CTRL_OFS, 32'h0);
        apb(1'b0, PTD_STATUS_OFS, 32'h0);
        chk(rd[0], 1'b0, "source one");
        $display("test regs done");
    endtask : t_regs
    task t_glitch;
        apb(1'b1, PTD_GLITCH_OFS, 32'h5);
        apb(1'b1, PTD_CTRL_OFS, 32'h40);
        pls(HI, LO, 3); chk(n, 1, "accept narrow");
        pls(HI, LO, 7); chk(n, 0, "accept wide");
        apb(1'b1, PTD_CTRL_OFS, 32'h50);
        pls(HI, LO, 3); chk(n, 0, "reject narrow");
        pls(HI, LO, 7); chk(n, 1, "reject wide");
        apb(1'b1, PTD_CTRL_OFS, 32'h48);
        pls(LO, HI, 3); chk(n, 1, "either negative");
        $display("test glitch done");
    endtask : t_glitch
    task t_runt;
        apb(1'b1, PTD_RHIGH_OFS, 32'hc8);
        apb(1'b1, PTD_RLOW_OFS, 32'h32);
        apb(1'b1, PTD_CTRL_OFS, 32'h41);
        pls(HI, LO, 3); chk(n, 1, "positive runt");
        pls(16'h012c, LO, 3); chk(n, 0, "full pulse");
        apb(1'b1, PTD_CTRL_OFS, 32'h45);
        pls(HI, 16'h012c, 3); chk(n, 1, "negative runt");
        $display("test runt done");
    endtask : t_runt
    task t_width;
        apb(1'b1, PTD_UPPER_OFS, 32'h6);
        apb(1'b1, PTD_LOWER_OFS, 32'h20);
        apb(1'b0, PTD_LOWER_OFS, 32'h0);
        chk(rd, 32'h6, "lower clamp");
        apb(1'b1, PTD_LOWER_OFS, 32'h4);
        apb(1'b1, PTD_CTRL_OFS, 32'h42);
        pls(HI, LO, 5); chk(n, 1, "within");
        pls(HI, LO, 8); chk(n, 0, "within wide");
        apb(1'b1, PTD_CTRL_OFS, 32'h62);
        pls(HI, LO, 8); chk(n, 1, "outside wide");
        pls(HI, LO, 2); chk(n, 1, "outside narrow");
        pls(HI, LO, 4); chk(n, 0, "outside at lower");
        $display("test width done");
    endtask : t_width
    task t_mode;
        apb(1'b1, PTD_CTRL_OFS, 32'h40);
        apb(1'b1, PTD_HOLDOFF_OFS, 32'h32);
        pls(HI, LO, 3); chk(n, 1, "before holdoff");
        pls(HI, LO, 3); chk(n, 0, "holdoff");
        apb(1'b1, PTD_HOLDOFF_OFS, 32'h0);
        repeat (60) @(posedge clk);
        apb(1'b1, PTD_CMD_OFS, 32'h1);
        n = 0;
        repeat (20) begin
            @(posedge clk);
            if (acq === 1'b1) n++;
        end
        chk(n, 1, "force once");
        apb(1'b1, PTD_TIMEOUT_OFS, 32'h14);
        apb(1'b1, PTD_CTRL_OFS, 32'h0);
        n = 0;
        repeat (60) begin
            @(posedge clk);
            if (acq === 1'b1) n++;
        end
        chk(n >= 2 && n <= 4, 1, "auto timeout");
        $display("test mode done");
    endtask : t_mode
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_glitch();
        t_runt();
        t_width();
        t_mode();
        conclude();
    end
endmodule : ptd_pulse_trigger_detector_test
`default_nettype wire
